// file: hdl/sram_port_pkg.sv
// Shared widths, encodings and reset values for the late-write memory port.
package sram_port_pkg;
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 262144;
  localparam int CHECK_BIT_POS = 8;
  localparam int SEQ_W = 2;

  localparam logic [SEQ_W-1:0] SEQ_RESET = 2'h0;
  localparam logic [SEQ_W-1:0] SEQ_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_OFF_N = 4'hF;

  typedef enum logic [1:0] {
    OP_DESELECT,
    OP_READ,
    OP_WRITE
  } op_t;

  // Low address bits of a burst beat, either linear or interleaved.
  function automatic logic [SEQ_W-1:0] burst_lsb(input logic [SEQ_W-1:0] base,
                                                 input logic [SEQ_W-1:0] step,
                                                 input logic interleave);
    logic [SEQ_W-1:0] r;
    r = interleave ? (base ^ step) : SEQ_W'(base + step);
    return r;
  endfunction

  // Replaces the lanes that are enabled in old data by new data.
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_data,
                                                   input logic [DATA_W-1:0] new_data,
                                                   input logic [LANES-1:0] lanes);
    logic [DATA_W-1:0] r;
    r = old_data;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        r[i*LANE_W +: LANE_W] = new_data[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction
endpackage

// file: hdl/sram_link_if.sv
// Pin-level link between the memory device and its controller.
`timescale 1ns/1ps
interface sram_link_if;
  import sram_port_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic chip_en_n;
  logic chip_select_high;
  logic chip_select_secondary_n;
  logic advance_load_strobe;
  logic rw_n;
  logic [LANES-1:0] lane_write_en_n;
  logic clk_en_n;
  logic out_en_n;
  logic snooze_request;
  logic burst_interleave;
  logic [DATA_W-1:0] dev_dq_out;
  logic dev_dq_oe;
  logic [DATA_W-1:0] ctrl_dq_out;
  logic ctrl_dq_oe;
  logic [DATA_W-1:0] dq;

  // The shared data bus idles high when nobody drives it.
  assign dq = dev_dq_oe ? dev_dq_out : (ctrl_dq_oe ? ctrl_dq_out : '1);

  modport memory (
    input addr, chip_en_n, chip_select_high, chip_select_secondary_n,
    input advance_load_strobe, rw_n, lane_write_en_n, clk_en_n,
    input out_en_n, snooze_request, burst_interleave, dq,
    output dev_dq_out, dev_dq_oe
  );

  modport controller (
    output addr, chip_en_n, chip_select_high, chip_select_secondary_n,
    output advance_load_strobe, rw_n, lane_write_en_n, clk_en_n,
    output out_en_n, snooze_request, burst_interleave,
    output ctrl_dq_out, ctrl_dq_oe,
    input dq
  );
endinterface

// file: hdl/late_write_sram.sv
// Synchronous late-write static memory with burst counter and flow-through reads.
`timescale 1ns/1ps
module late_write_sram
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sram_link_if.memory link
);

  // This is the 36-bit organisation: bit 8 of each lane is its check bit.
  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // Static strap and standby request arrive from outside the clock domain.
  logic mode_meta_q;
  logic mode_meta_d;
  logic mode_q;
  logic mode_d;
  logic snooze_meta_q;
  logic snooze_meta_d;
  logic snooze_q;
  logic snooze_d;

  // Access pipeline. The address stage holds the loaded cycle type and burst state.
  // The write stage keeps what a late write needs until its data cycle arrives.
  op_t op_q;
  op_t op_d;
  logic [ADDR_W-1:SEQ_W] addr_hi_q;
  logic [ADDR_W-1:SEQ_W] addr_hi_d;
  logic [SEQ_W-1:0] base_q;
  logic [SEQ_W-1:0] base_d;
  logic [SEQ_W-1:0] step_q;
  logic [SEQ_W-1:0] step_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [ADDR_W-1:0] wr_addr_d;
  logic [LANES-1:0] wr_lanes_q;
  logic [LANES-1:0] wr_lanes_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic drive_q;
  logic drive_d;

  logic running;
  logic loading;
  logic selected;
  logic wr_commit;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] array_word;
  logic [DATA_W-1:0] commit_word;

  // Only the second stage of each synchroniser is read by the access logic.
  always_comb begin
    mode_meta_d = link.burst_interleave;
    mode_d = mode_meta_q;
    snooze_meta_d = link.snooze_request;
    snooze_d = snooze_meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_meta_q <= 1'b0;
      mode_q <= 1'b0;
      snooze_meta_q <= 1'b0;
      snooze_q <= 1'b0;
    end else begin
      mode_meta_q <= mode_meta_d;
      mode_q <= mode_d;
      snooze_meta_q <= snooze_meta_d;
      snooze_q <= snooze_d;
    end
  end

  assign running = ~link.clk_en_n;
  assign loading = ~link.advance_load_strobe;
  assign selected = ~link.chip_en_n & link.chip_select_high & ~link.chip_select_secondary_n;

  // Cycle type of a load edge: an inactive chip enable or standby makes it a deselect.
  function automatic op_t load_op(input logic sel, input logic standby, input logic rd);
    op_t r;
    if (!sel || standby) begin
      r = OP_DESELECT;
    end else if (rd) begin
      r = OP_READ;
    end else begin
      r = OP_WRITE;
    end
    return r;
  endfunction

  // One pass per running edge. A suspended edge leaves every pipeline register as it was,
  // so a write whose data cycle was suspended still waits for its data on the
  // next running edge.
  always_comb begin
    op_d = op_q;
    addr_hi_d = addr_hi_q;
    base_d = base_q;
    step_d = step_q;
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    wr_lanes_d = wr_lanes_q;
    rd_data_d = rd_data_q;
    drive_d = drive_q;
    wr_commit = 1'b0;
    acc_addr = wr_addr_q;
    array_word = DATA_RESET;
    if (running) begin
      // The data of a write taken on the previous edge is on the bus now.
      wr_commit = wr_pend_q;
      if (loading) begin
        // A fresh address may be loaded on every cycle; no burst is needed.
        // Chip enables and the read/write pin count only on a load edge.
        op_d = load_op(selected, snooze_q, link.rw_n);
        addr_hi_d = link.addr[ADDR_W-1:SEQ_W];
        base_d = link.addr[SEQ_W-1:0];
        step_d = SEQ_RESET;
        acc_addr = link.addr;
      end else begin
        // Advance keeps the loaded cycle type and steps the low bits.
        // Standby turns the remaining beats into deselects; a pending write still lands.
        if (snooze_q) begin
          op_d = OP_DESELECT;
        end
        // Beat zero was the loaded address, so the group of four wraps back onto it.
        step_d = SEQ_W'(step_q + SEQ_STEP);
        acc_addr = {addr_hi_q, burst_lsb(base_q, step_d, mode_q)};
      end
      // Lane enables are taken with the address, never with the data.
      wr_pend_d = (op_d == OP_WRITE);
      wr_addr_d = acc_addr;
      wr_lanes_d = ~link.lane_write_en_n;
      // The drive flop only records an accepted read; the pin gates follow it below.
      drive_d = (op_d == OP_READ);
      if (op_d == OP_READ) begin
        array_word = mem[acc_addr];
        // A read right behind a write to the same word sees the new data.
        // That data is on the bus in this very cycle, so it is merged here.
        if (wr_commit && (wr_addr_q == acc_addr)) begin
          rd_data_d = lane_merge(array_word, link.dq, wr_lanes_q);
        end else begin
          rd_data_d = array_word;
        end
      end
    end
  end

  // Reset clears the controls of the pipeline, never the array.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q <= OP_DESELECT;
      addr_hi_q <= ADDR_RESET[ADDR_W-1:SEQ_W];
      base_q <= SEQ_RESET;
      step_q <= SEQ_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= ADDR_RESET;
      wr_lanes_q <= LANES_NONE;
      rd_data_q <= DATA_RESET;
      drive_q <= 1'b0;
    end else begin
      op_q <= op_d;
      addr_hi_q <= addr_hi_d;
      base_q <= base_d;
      step_q <= step_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      wr_lanes_q <= wr_lanes_d;
      rd_data_q <= rd_data_d;
      drive_q <= drive_d;
    end
  end

  // The array itself has no reset; only enabled lanes are touched.
  always_comb begin
    commit_word = lane_merge(mem[wr_addr_q], link.dq, wr_lanes_q);
  end

  always_ff @(posedge clk) begin
    if (wr_commit) begin
      mem[wr_addr_q] <= commit_word;
    end
  end

  // Read data leaves straight from its flop; only the enable is combinational.
  // Output enable and standby act on the drivers without waiting for a clock.
  assign link.dev_dq_out = rd_data_q;
  assign link.dev_dq_oe = drive_q & ~link.out_en_n & ~link.snooze_request;

endmodule

// file: hdl/sram_port_master.sv
// Controller end that turns user commands into late-write pin cycles.
`timescale 1ns/1ps
module sram_port_master
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sram_link_if.controller link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_advance,
  input wire logic cmd_hold,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [LANES-1:0] cmd_lanes,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic snooze_in,
  input wire logic interleave_in,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_valid
);

  logic [ADDR_W-1:0] addr_q, addr_d;
  logic ce_n_q, ce_n_d;
  logic adv_q, adv_d;
  logic rw_n_q, rw_n_d;
  logic [LANES-1:0] lanes_n_q, lanes_n_d;
  logic cke_n_q, cke_n_d;
  logic zz_q;
  logic mode_q;
  op_t pin_op_q, pin_op_d;
  op_t last_op_q, last_op_d;
  logic [DATA_W-1:0] wdata_pend_q, wdata_pend_d;
  logic [DATA_W-1:0] wdata_out_q, wdata_out_d;
  logic wr_drive_q, wr_drive_d;
  logic rd_wait_q, rd_wait_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rdata_valid_q, rdata_valid_d;

  always_comb begin
    addr_d = addr_q;
    ce_n_d = 1'b1;
    adv_d = 1'b0;
    rw_n_d = 1'b1;
    lanes_n_d = LANES_OFF_N;
    cke_n_d = 1'b0;
    pin_op_d = OP_DESELECT;
    last_op_d = last_op_q;
    wdata_pend_d = wdata_pend_q;
    if (cmd_hold) begin
      cke_n_d = 1'b1;
    end else if (cmd_advance) begin
      adv_d = 1'b1;
      ce_n_d = 1'b0;
      pin_op_d = last_op_q;
      rw_n_d = (last_op_q != OP_WRITE);
      lanes_n_d = (last_op_q == OP_WRITE) ? ~cmd_lanes : LANES_OFF_N;
      wdata_pend_d = cmd_wdata;
    end else begin
      // Each load names its own address; bursting is optional.
      addr_d = cmd_addr;
      ce_n_d = ~cmd_valid;
      rw_n_d = ~(cmd_valid & cmd_write);
      lanes_n_d = (cmd_valid & cmd_write) ? ~cmd_lanes : LANES_OFF_N;
      pin_op_d = !cmd_valid ? OP_DESELECT : (cmd_write ? OP_WRITE : OP_READ);
      last_op_d = pin_op_d;
      wdata_pend_d = cmd_wdata;
    end
    // Stage after the device edge: drive write data or collect read data.
    if (!cke_n_q) begin
      wr_drive_d = (pin_op_q == OP_WRITE);
      wdata_out_d = wdata_pend_q;
      rd_wait_d = (pin_op_q == OP_READ);
    end else begin
      wr_drive_d = wr_drive_q;
      wdata_out_d = wdata_out_q;
      rd_wait_d = 1'b0;
    end
    rdata_valid_d = rd_wait_q;
    rdata_d = rd_wait_q ? link.dq : rdata_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= ADDR_RESET;
      ce_n_q <= 1'b1;
      adv_q <= 1'b0;
      rw_n_q <= 1'b1;
      lanes_n_q <= LANES_OFF_N;
      cke_n_q <= 1'b0;
      zz_q <= 1'b0;
      mode_q <= 1'b0;
      pin_op_q <= OP_DESELECT;
      last_op_q <= OP_DESELECT;
      wdata_pend_q <= DATA_RESET;
      wdata_out_q <= DATA_RESET;
      wr_drive_q <= 1'b0;
      rd_wait_q <= 1'b0;
      rdata_q <= DATA_RESET;
      rdata_valid_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      ce_n_q <= ce_n_d;
      adv_q <= adv_d;
      rw_n_q <= rw_n_d;
      lanes_n_q <= lanes_n_d;
      cke_n_q <= cke_n_d;
      zz_q <= snooze_in;
      mode_q <= interleave_in;
      pin_op_q <= pin_op_d;
      last_op_q <= last_op_d;
      wdata_pend_q <= wdata_pend_d;
      wdata_out_q <= wdata_out_d;
      wr_drive_q <= wr_drive_d;
      rd_wait_q <= rd_wait_d;
      rdata_q <= rdata_d;
      rdata_valid_q <= rdata_valid_d;
    end
  end

  assign link.addr = addr_q;
  assign link.chip_en_n = ce_n_q;
  assign link.chip_select_high = 1'b1;
  assign link.chip_select_secondary_n = 1'b0;
  assign link.advance_load_strobe = adv_q;
  assign link.rw_n = rw_n_q;
  assign link.lane_write_en_n = lanes_n_q;
  assign link.clk_en_n = cke_n_q;
  assign link.out_en_n = 1'b0;
  assign link.snooze_request = zz_q;
  assign link.burst_interleave = mode_q;
  assign link.ctrl_dq_out = wdata_out_q;
  assign link.ctrl_dq_oe = wr_drive_q;
  assign rdata = rdata_q;
  assign rdata_valid = rdata_valid_q;

endmodule

// file: verification/sram_link_chk.sv
// Concurrent checks on the pins between the memory and its controller.
`timescale 1ns/1ps
module sram_link_chk
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_en_n,
  input wire logic advance_load_strobe,
  input wire logic rw_n,
  input wire logic clk_en_n,
  input wire logic out_en_n,
  input wire logic snooze_request,
  input wire logic dev_dq_oe,
  input wire logic [DATA_W-1:0] dev_dq_out,
  input wire logic ctrl_dq_oe,
  input wire logic [DATA_W-1:0] ctrl_dq_out,
  input wire logic [DATA_W-1:0] dq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic ld = !clk_en_n && !advance_load_strobe;
  wire logic rd_ld = ld && !chip_en_n && rw_n;
  sequence s_rd_load;
    ld && !chip_en_n && rw_n;
  endsequence
  sequence s_wr_load;
    ld && !chip_en_n && !rw_n;
  endsequence
  sequence s_ds_load;
    ld && chip_en_n;
  endsequence
  AST_WR_DATA_NEXT: assert property (s_wr_load |=> ctrl_dq_oe)
    else $error("write data not driven one cycle after the write address");
  AST_WR_BUS: assert property (ctrl_dq_oe |-> dq == ctrl_dq_out && !dev_dq_oe)
    else $error("write data cycle finds the bus contended");
  AST_RD_DRIVE: assert property (s_rd_load |=> dev_dq_oe && dq == dev_dq_out)
    else $error("read load not followed by driven read data");
  AST_DESEL: assert property (s_ds_load |=> !dev_dq_oe)
    else $error("deselect load left the data drivers on");
  AST_DRIVE_CAUSE: assert property ($rose(dev_dq_oe) |-> $past(rd_ld))
    else $error("data drivers turned on without a read load");
  AST_FREEZE: assert property (clk_en_n |=> $stable(dev_dq_oe) && $stable(dev_dq_out))
    else $error("output state moved on an ignored edge");
  AST_OE_GATE: assert property (dev_dq_oe |-> !out_en_n && !snooze_request)
    else $error("data drivers on while output enable or standby forbids it");
  AST_WR_RD_TURN: assert property (s_wr_load ##1 s_rd_load |=> dev_dq_oe && !ctrl_dq_oe)
    else $error("write then read needed a turnaround cycle");
endmodule

// file: verification/tb_top.sv
// Random and directed traffic through the controller end into the memory end.
`timescale 1ns/1ps
module tb_top;
  import sram_port_pkg::*;
  localparam logic [ADDR_W-1:0] REGION = 18'h00100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_advance = 1'b0, cmd_hold = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = ADDR_RESET;
  logic [LANES-1:0] cmd_lanes = LANES_NONE;
  logic [DATA_W-1:0] cmd_wdata = DATA_RESET;
  logic interleave_in = 1'b0, snooze_in = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic rdata_valid;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] exp_q [$];
  logic [ADDR_W-1:0] base = ADDR_RESET;
  logic [6:0] pv_pin = 7'h00;
  int stp = 0, ty = 0, pv = 0, miscompares = 0, checked = 0;
  always #50 clk = ~clk;
  sram_link_if link();
  late_write_sram u_late_write_sram (.clk(clk), .rst(rst), .link(link));
  sram_port_master u_sram_port_master (.clk(clk), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_advance(cmd_advance),
    .cmd_hold(cmd_hold), .cmd_addr(cmd_addr), .cmd_lanes(cmd_lanes), .cmd_wdata(cmd_wdata),
    .snooze_in(snooze_in), .interleave_in(interleave_in), .rdata(rdata),
    .rdata_valid(rdata_valid));
  sram_link_chk u_sram_link_chk (.clk(clk), .rst(rst), .chip_en_n(link.chip_en_n),
    .advance_load_strobe(link.advance_load_strobe), .rw_n(link.rw_n),
    .clk_en_n(link.clk_en_n), .out_en_n(link.out_en_n), .snooze_request(link.snooze_request),
    .dev_dq_oe(link.dev_dq_oe), .dev_dq_out(link.dev_dq_out), .ctrl_dq_oe(link.ctrl_dq_oe),
    .ctrl_dq_out(link.ctrl_dq_out), .dq(link.dq));
  function automatic logic [1:0] beat(input logic [1:0] b, input int s, input logic il);
    return il ? (b ^ 2'(s)) : 2'(b + 2'(s));
  endfunction
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] n, input logic [LANES-1:0] l);
    for (int i = 0; i < LANES; i++) begin
      if (l[i]) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    end
    return o;
  endfunction
  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$urandom(), $urandom()});
  endfunction
  task automatic cmp_data(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [6:0] g, input logic [6:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ops: 0 deselect, 1 read, 2 write, 3 burst advance, 4 clock hold.
  task automatic step(input int op, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
      input logic [DATA_W-1:0] wd);
    logic [ADDR_W-1:0] ea;
    int eff;
    if (pv == 1) cmp_pin({link.advance_load_strobe, link.chip_en_n, link.rw_n | pv_pin[5],
      link.lane_write_en_n | {4{pv_pin[4]}}}, pv_pin);
    if (pv == 2) cmp_pin({6'h00, link.advance_load_strobe}, 7'h01);
    cmd_valid = (op == 1) || (op == 2);
    cmd_write = op == 2;
    cmd_advance = op == 3;
    cmd_hold = op == 4;
    cmd_addr = a;
    cmd_lanes = ln;
    cmd_wdata = wd;
    pv = op == 4 ? 0 : (op == 3 ? 2 : 1);
    pv_pin = {1'b0, op == 0, op != 2, op == 2 ? ~ln : 4'hF};
    eff = op == 3 ? ty : op;
    ea = a;
    if (op < 3) begin
      base = a;
      stp = 0;
      ty = op;
    end else if (op == 3) begin
      stp++;
      ea = {base[ADDR_W-1:2], beat(base[1:0], stp, interleave_in)};
    end
    if (eff == 1) exp_q.push_back(mem[ea]);
    if (eff == 2 && !snooze_in) mem[ea] = merge(mem[ea], wd, ln);
    @(negedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) step(0, REGION, LANES_OFF_N, DATA_RESET);
  endtask
  task automatic close_out();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rdata_valid === 1'b1) begin
      if (exp_q.size() > 0) cmp_data(rdata, exp_q.pop_front());
      else cmp_data(DATA_RESET, ~DATA_RESET);
    end
  end
  initial begin
    void'($urandom(26652));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) step(2, REGION + 18'(i), LANES_OFF_N, rnd());
    for (int i = 0; i < 8; i++) begin
      step(1, REGION + 18'(i), LANES_OFF_N, DATA_RESET);
      step(2, REGION + 18'(7 - i), 4'(1 << (i % 4)), rnd());
    end
    idle(6);
    $display("test fill done");
    // Check bits only, then standby: writes during standby must not land.
    step(2, REGION, 4'hF, 36'h804020100);
    idle(2);
    snooze_in = 1'b1;
    idle(4);
    step(2, REGION, 4'hF, rnd());
    step(2, REGION + 18'h1, 4'h3, rnd());
    idle(2);
    snooze_in = 1'b0;
    idle(4);
    step(1, REGION, LANES_OFF_N, DATA_RESET);
    step(1, REGION + 18'h1, LANES_OFF_N, DATA_RESET);
    idle(6);
    $display("test standby done");
    for (int il = 0; il < 2; il++) begin
      interleave_in = 1'(il);
      idle(6);
      step(1, REGION + 18'h2, LANES_OFF_N, DATA_RESET);
      repeat (4) step(3, ADDR_RESET, LANES_OFF_N, DATA_RESET);
      step(2, REGION + 18'h5, 4'h5, rnd());
      repeat (4) step(3, ADDR_RESET, 4'hA, rnd());
      step(1, REGION + 18'h7, LANES_OFF_N, DATA_RESET);
      step(4, ADDR_RESET, LANES_OFF_N, DATA_RESET);
      repeat (3) step(3, ADDR_RESET, LANES_OFF_N, DATA_RESET);
      step(0, REGION, LANES_OFF_N, DATA_RESET);
      repeat (2) step(3, ADDR_RESET, LANES_OFF_N, DATA_RESET);
      idle(6);
      $display("test burst mode %0d done", il);
    end
    for (int il = 0; il < 2; il++) begin
      interleave_in = 1'(il);
      idle(6);
      repeat (150) step($urandom % 5, REGION + 18'($urandom % 8), 4'($urandom_range(15, 1)),
        rnd());
      idle(6);
      $display("test random mode %0d done", il);
    end
    cmp_data(DATA_W'(exp_q.size()), DATA_RESET);
    close_out();
  end
  initial begin
    #500000;
    miscompares++;
    close_out();
  end
endmodule
